/* File: common/aoic_pkg.sv */
package aoic_pkg;

    // Register byte addresses on the register bus.
    localparam logic [23:0] ADDR_IN_CFG = 24'h32_0120;
    localparam logic [23:0] ADDR_IN_RATE = 24'h32_0124;
    localparam logic [23:0] ADDR_OUT_CFG = 24'h32_0128;
    localparam logic [23:0] ADDR_PATH = 24'h32_058c;
    localparam logic [23:0] ADDR_VOL = 24'h32_0594;
    localparam logic [23:0] ADDR_BAL = 24'h32_0598;
    localparam logic [23:0] ADDR_ROUTE = 24'h32_05ec;

    // Reset values and writable masks.
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] IN_CFG_MASK = 16'h0007;
    localparam logic [15:0] BAL_MASK = 16'h007f;

    // Field positions.
    localparam int IN_ROLE_BIT = 0;
    localparam int IN_FMT_BIT = 1;
    localparam int IN_RDIS_BIT = 2;
    localparam int OUT_FMT_BIT = 0;
    localparam int OUT_MUTE_BIT = 1;
    localparam int PATH_DMX_LSB = 7;
    localparam int PATH_OVR_BIT = 10;
    localparam int PATH_DAC_EN_BIT = 12;
    localparam int PATH_OUT_EN_BIT = 13;
    localparam int PATH_STR2DAC_BIT = 14;
    localparam int PATH_IN_EN_BIT = 15;
    localparam int VOL_SRC_MUTE_BIT = 6;
    localparam int VOL_OUT_MUTE_BIT = 7;
    localparam int VOL_DAC_MUTE_BIT = 8;
    localparam int BAL_SEL_BIT = 6;
    localparam int RT_OSC_OUT_BIT = 0;
    localparam int RT_OSC_IN_BIT = 1;
    localparam int RT_OUT2IN_BIT = 2;
    localparam int RT_LOOP_BIT = 3;

    // Stereo recombination codes.
    typedef enum logic [1:0] {
        AOIC_DMX_SUMDIFF = 2'b00,
        AOIC_DMX_SUMR = 2'b01,
        AOIC_DMX_LR = 2'b10,
        AOIC_DMX_MONO = 2'b11
    } aoic_dmx_e;

    // Fractional gains for 0 to 5 dB in Q15; each 6 dB is one shift.
    localparam logic [16:0] ATT_FRAC [6] = '{17'h0_8000, 17'h0_7215,
        17'h0_65ad, 17'h0_5a9e, 17'h0_50c3, 17'h0_47fb};

    // Timing.
    localparam longint CLK_HZ = 50_000_000;
    localparam longint BASE_RATE_HZ = 48_000;
    localparam longint OSC_RATIO = 256;
    localparam int NCO_W = 24;
    localparam longint OSC_INC_L =
        ((BASE_RATE_HZ * OSC_RATIO * 2) << NCO_W) / CLK_HZ;
    localparam logic [NCO_W-1:0] OSC_INC = OSC_INC_L[NCO_W-1:0];
    localparam int BASE_PERIOD = int'(CLK_HZ / BASE_RATE_HZ);
    localparam int RATE_NONE_CYCLES = 2 * BASE_PERIOD;
    localparam int RATE_MAX_OK = 4;
    localparam longint STARTUP_MUTE_US = 10_000;
    localparam int STARTUP_CYCLES =
        int'((CLK_HZ / 1_000_000) * STARTUP_MUTE_US);

endpackage

/* File: hdl/aoic_top.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module aoic_top #(
    parameter int STARTUP_CYCLES = aoic_pkg::STARTUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [23:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] demod_ch1,
    input wire logic signed [15:0] demod_ch2,
    input wire logic demod_valid,
    input wire logic [1:0] demod_auto_mode,
    input wire logic demod_lock_lost,
    input wire logic serial_in_bit_clock_pin_i,
    output logic serial_in_bit_clock_pin_o,
    output logic serial_in_bit_clock_pin_oe_n,
    input wire logic serial_in_word_clock_pin_i,
    output logic serial_in_word_clock_pin_o,
    output logic serial_in_word_clock_pin_oe_n,
    input wire logic serial_in_data_pin_i,
    output logic serial_in_data_pin_o,
    output logic serial_in_data_pin_oe_n,
    output logic serial_out_bit_clock,
    output logic serial_out_word_clock,
    output logic serial_out_data,
    output logic signed [15:0] rx_left,
    output logic signed [15:0] rx_right,
    output logic rx_valid,
    output logic signed [15:0] dac_left,
    output logic signed [15:0] dac_right,
    output logic dac_valid
);

    localparam int ST_W = $clog2(STARTUP_CYCLES + 1);

    logic [15:0] in_cfg_q, out_cfg_q, path_q, vol_q, bal_q, route_q;
    logic [5:0] rate_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q, rd_d;
    logic hit_d, ro_d;
    logic [ST_W-1:0] st_cnt_q;
    logic startup_q;

    // Saturates a wide signed value to sixteen bits.
    function automatic logic signed [15:0] sat(input logic signed [17:0] v);
        logic signed [15:0] r;
        r = v[15:0];
        if (v > 18'sh0_7fff) begin
            r = 16'sh7fff;
        end else if (v < -18'sh0_8000) begin
            r = -16'sh8000;
        end
        return r;
    endfunction

    // Attenuates by n dB: a fractional gain then one shift per 6 dB.
    function automatic logic signed [15:0] atten(
        input logic signed [15:0] s, input logic [5:0] n);
        logic signed [33:0] p;
        logic [2:0] r;
        logic [3:0] q;
        r = 3'(n % 6);
        q = 4'(n / 6);
        p = 34'(s) * $signed({1'b0, aoic_pkg::ATT_FRAC[r]});
        p = p >>> 15;
        p = p >>> q;
        return p[15:0];
    endfunction

    // Maps a word-clock period to the nearest multiple of the base rate.
    function automatic logic [5:0] rate_code(input logic [15:0] per);
        logic [5:0] c;
        c = 6'h07;
        for (int k = 6; k >= 1; k--) begin
            if (32'(per) >= (2 * aoic_pkg::BASE_PERIOD) / (2 * k + 1)) begin
                c = 6'(k);
            end
        end
        return c;
    endfunction

    // Read decode; unmapped addresses answer with an error.
    always_comb begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        ro_d = 1'b0;
        case (paddr)
            aoic_pkg::ADDR_IN_CFG: rd_d[15:0] = in_cfg_q;
            aoic_pkg::ADDR_IN_RATE: begin
                rd_d[5:0] = rate_q;
                ro_d = 1'b1;
            end
            aoic_pkg::ADDR_OUT_CFG: rd_d[15:0] = out_cfg_q;
            aoic_pkg::ADDR_PATH: rd_d[15:0] = path_q;
            aoic_pkg::ADDR_VOL: rd_d[15:0] = vol_q;
            aoic_pkg::ADDR_BAL: rd_d[15:0] = bal_q;
            aoic_pkg::ADDR_ROUTE: rd_d[15:0] = route_q;
            default: hit_d = 1'b0;
        endcase
    end

    // Bus answer one cycle into the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !hit_d || (pwrite && ro_d);
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Register writes take effect at the completing edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_cfg_q <= aoic_pkg::REG_RESET;
            out_cfg_q <= aoic_pkg::REG_RESET;
            path_q <= aoic_pkg::REG_RESET;
            vol_q <= aoic_pkg::REG_RESET;
            bal_q <= aoic_pkg::REG_RESET;
            route_q <= aoic_pkg::REG_RESET;
        end else if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                aoic_pkg::ADDR_IN_CFG:
                    in_cfg_q <= pwdata[15:0] & aoic_pkg::IN_CFG_MASK;
                aoic_pkg::ADDR_OUT_CFG: out_cfg_q <= pwdata[15:0];
                aoic_pkg::ADDR_PATH: path_q <= pwdata[15:0];
                aoic_pkg::ADDR_VOL: vol_q <= pwdata[15:0];
                aoic_pkg::ADDR_BAL: bal_q <= pwdata[15:0] & aoic_pkg::BAL_MASK;
                aoic_pkg::ADDR_ROUTE: route_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Startup timer keeps every mute forced after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_cnt_q <= '0;
            startup_q <= 1'b1;
        end else if (startup_q) begin
            st_cnt_q <= st_cnt_q + 1'b1;
            startup_q <= (32'(st_cnt_q) < STARTUP_CYCLES - 1);
        end
    end

    logic src_mute, out_hold, dac_on;
    assign src_mute = vol_q[aoic_pkg::VOL_SRC_MUTE_BIT] | startup_q
        | demod_lock_lost;
    assign out_hold = vol_q[aoic_pkg::VOL_OUT_MUTE_BIT]
        | out_cfg_q[aoic_pkg::OUT_MUTE_BIT] | startup_q
        | !path_q[aoic_pkg::PATH_OUT_EN_BIT];
    assign dac_on = path_q[aoic_pkg::PATH_DAC_EN_BIT] & !startup_q
        & !vol_q[aoic_pkg::VOL_DAC_MUTE_BIT];

    aoic_pkg::aoic_dmx_e dmx_sel;
    logic signed [17:0] a18, b18;
    logic signed [15:0] s1_l_q, s1_r_q, s2_l_q, s2_r_q, proc_l_q, proc_r_q;
    logic s1_v_q, s2_v_q, proc_v_q;

    // Stereo recombination, automatic unless software overrides it.
    always_comb begin
        dmx_sel = aoic_pkg::aoic_dmx_e'(demod_auto_mode);
        if (path_q[aoic_pkg::PATH_OVR_BIT]) begin
            dmx_sel = aoic_pkg::aoic_dmx_e'(
                path_q[aoic_pkg::PATH_DMX_LSB +: 2]);
        end
        a18 = 18'(demod_ch1);
        b18 = 18'(demod_ch2);
    end

    // Three stages: recombine, balance, then volume and source mute.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_l_q <= '0;
            s1_r_q <= '0;
            s2_l_q <= '0;
            s2_r_q <= '0;
            proc_l_q <= '0;
            proc_r_q <= '0;
            s1_v_q <= 1'b0;
            s2_v_q <= 1'b0;
            proc_v_q <= 1'b0;
        end else begin
            s1_v_q <= demod_valid;
            s2_v_q <= s1_v_q;
            proc_v_q <= s2_v_q;
            if (demod_valid) begin
                case (dmx_sel)
                    aoic_pkg::AOIC_DMX_SUMDIFF: begin
                        s1_l_q <= sat(a18 + b18);
                        s1_r_q <= sat(a18 - b18);
                    end
                    aoic_pkg::AOIC_DMX_SUMR: begin
                        s1_l_q <= sat((a18 <<< 1) - b18);
                        s1_r_q <= demod_ch2;
                    end
                    aoic_pkg::AOIC_DMX_LR: begin
                        s1_l_q <= demod_ch1;
                        s1_r_q <= demod_ch2;
                    end
                    default: begin
                        s1_l_q <= sat((a18 + b18) >>> 1);
                        s1_r_q <= sat((a18 + b18) >>> 1);
                    end
                endcase
            end
            if (s1_v_q) begin
                s2_l_q <= bal_q[aoic_pkg::BAL_SEL_BIT] ? s1_l_q
                    : atten(s1_l_q, bal_q[5:0]);
                s2_r_q <= bal_q[aoic_pkg::BAL_SEL_BIT]
                    ? atten(s1_r_q, bal_q[5:0]) : s1_r_q;
            end
            if (s2_v_q) begin
                proc_l_q <= src_mute ? 16'sh0000
                    : atten(s2_l_q, vol_q[5:0]);
                proc_r_q <= src_mute ? 16'sh0000
                    : atten(s2_r_q, vol_q[5:0]);
            end
        end
    end

    // Oversample clock generator: accumulator carry ticks each half period.
    localparam int NCO_W_L = aoic_pkg::NCO_W;
    logic [NCO_W_L-1:0] acc_q;
    logic tick_q, fall_evt, frame_start, tx_bit, tx_bit_q;
    logic [8:0] cnt_q, nc;
    logic [4:0] pos, idx;
    logic signed [15:0] tx_l_q, tx_r_q, word;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
            tick_q <= 1'b0;
            cnt_q <= 9'h000;
        end else begin
            {tick_q, acc_q} <= {1'b0, acc_q}
                + {1'b0, aoic_pkg::OSC_INC};
            if (tick_q) begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end

    // Next serial output bit, chosen at each bit-clock fall.
    always_comb begin
        nc = cnt_q + 9'h001;
        fall_evt = tick_q && (cnt_q[2:0] == 3'h7);
        frame_start = tick_q && (cnt_q == 9'h1ff);
        pos = nc[7:3];
        idx = pos - {4'h0, !out_cfg_q[aoic_pkg::OUT_FMT_BIT]};
        word = nc[8] ? tx_r_q : (frame_start ? proc_l_q : tx_l_q);
        tx_bit = 1'b0;
        if ((pos >= {4'h0, !out_cfg_q[aoic_pkg::OUT_FMT_BIT]})
            && (idx < 5'h10)) begin
            tx_bit = word[4'hf - idx[3:0]];
        end
    end

    // Output samples are held at each base-rate frame start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_l_q <= '0;
            tx_r_q <= '0;
            tx_bit_q <= 1'b0;
            dac_left <= '0;
            dac_right <= '0;
            dac_valid <= 1'b0;
        end else begin
            dac_valid <= frame_start;
            if (frame_start) begin
                tx_l_q <= proc_l_q;
                tx_r_q <= proc_r_q;
                dac_left <= !dac_on ? 16'sh0000
                    : path_q[aoic_pkg::PATH_STR2DAC_BIT] ? rx_left : proc_l_q;
                dac_right <= !dac_on ? 16'sh0000
                    : path_q[aoic_pkg::PATH_STR2DAC_BIT] ? rx_right : proc_r_q;
            end
            if (fall_evt) begin
                tx_bit_q <= tx_bit;
            end
        end
    end

    // Input pin synchronisers, order bit clock, word clock, data.
    logic [2:0] pin_s1_q, pin_s2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {serial_in_bit_clock_pin_i,
                serial_in_word_clock_pin_i, serial_in_data_pin_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    logic in_master;

    // Pin drivers; a frozen output port keeps its last levels, bar a routed oversample clock on its bit clock pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_bit_clock <= 1'b0;
            serial_out_word_clock <= 1'b0;
            serial_out_data <= 1'b0;
            serial_in_bit_clock_pin_o <= 1'b0;
            serial_in_word_clock_pin_o <= 1'b0;
            serial_in_data_pin_o <= 1'b0;
            serial_in_bit_clock_pin_oe_n <= 1'b1;
            serial_in_word_clock_pin_oe_n <= 1'b1;
            serial_in_data_pin_oe_n <= 1'b1;
        end else begin
            // The oversample clock leaves even while the port is held.
            if (route_q[aoic_pkg::RT_OSC_OUT_BIT]) begin
                serial_out_bit_clock <= cnt_q[0];
            end else if (!out_hold) begin
                serial_out_bit_clock <= cnt_q[2];
            end
            if (!out_hold) begin
                serial_out_word_clock <= cnt_q[8];
                serial_out_data <= route_q[aoic_pkg::RT_LOOP_BIT]
                    ? pin_s2_q[0] : tx_bit_q;
            end
            if (route_q[aoic_pkg::RT_OSC_IN_BIT]) begin
                serial_in_bit_clock_pin_o <= cnt_q[0];
                serial_in_word_clock_pin_o <= cnt_q[8];
                serial_in_data_pin_o <= 1'b0;
                serial_in_bit_clock_pin_oe_n <= 1'b0;
                serial_in_word_clock_pin_oe_n <= 1'b0;
                serial_in_data_pin_oe_n <= 1'b0;
            end else begin
                serial_in_bit_clock_pin_o <= cnt_q[2];
                serial_in_word_clock_pin_o <= cnt_q[8];
                serial_in_data_pin_o <= 1'b0;
                serial_in_bit_clock_pin_oe_n <= !in_master;
                serial_in_word_clock_pin_oe_n <= !in_master;
                serial_in_data_pin_oe_n <= 1'b1;
            end
        end
    end

    // Input clocking: own pins as slave, internal clocks as master or with the output clocks routed in.
    logic rx_int, rx_bclk, rx_ws, rx_bclk_p_q, rx_ws_p_q;
    logic rx_rise, ws_chg, ws_lat_q, in_win, frame_done;
    logic [5:0] bit_q, bpos;
    logic [15:0] sh_q, left_hold_q;
    logic [2:0] dec_q, ratio;
    logic [15:0] per_q;
    assign in_master = in_cfg_q[aoic_pkg::IN_ROLE_BIT]
        & !route_q[aoic_pkg::RT_OUT2IN_BIT];
    assign rx_int = route_q[aoic_pkg::RT_OUT2IN_BIT] | in_master;
    assign rx_bclk = rx_int ? cnt_q[2] : pin_s2_q[2];
    assign rx_ws = rx_int ? cnt_q[8] : pin_s2_q[1];
    assign rx_rise = rx_bclk && !rx_bclk_p_q;
    assign ws_chg = rx_ws != ws_lat_q;
    assign bpos = ws_chg ? 6'h00 : bit_q;
    assign in_win = (bpos >= {5'h00, !in_cfg_q[aoic_pkg::IN_FMT_BIT]})
        && (bpos < 6'h10 + {5'h00, !in_cfg_q[aoic_pkg::IN_FMT_BIT]});
    assign frame_done = rx_rise && ws_chg && ws_lat_q
        && path_q[aoic_pkg::PATH_IN_EN_BIT];
    assign ratio = (in_cfg_q[aoic_pkg::IN_RDIS_BIT] || rate_q == 6'h00
        || rate_q > 6'(aoic_pkg::RATE_MAX_OK)) ? 3'h1 : rate_q[2:0];

    // Receiver: keep the first sixteen bits of each word, drop surplus frames.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_bclk_p_q <= 1'b0;
            ws_lat_q <= 1'b0;
            bit_q <= 6'h00;
            sh_q <= 16'h0000;
            left_hold_q <= 16'h0000;
            dec_q <= 3'h0;
            rx_left <= '0;
            rx_right <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_bclk_p_q <= rx_bclk;
            rx_valid <= 1'b0;
            if (rx_rise) begin
                ws_lat_q <= rx_ws;
                bit_q <= (bpos == 6'h3f) ? bpos : bpos + 6'h01;
                if (ws_chg) begin
                    sh_q <= in_win ? {15'h0000, pin_s2_q[0]} : 16'h0000;
                    if (!ws_lat_q) begin
                        left_hold_q <= sh_q;
                    end
                end else if (in_win) begin
                    sh_q <= {sh_q[14:0], pin_s2_q[0]};
                end
            end
            if (frame_done) begin
                dec_q <= (dec_q + 3'h1 >= ratio) ? 3'h0 : dec_q + 3'h1;
                if (dec_q == 3'h0) begin
                    rx_left <= left_hold_q;
                    rx_right <= sh_q;
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // Rate detection from the word-clock period in system clocks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ws_p_q <= 1'b0;
            per_q <= 16'h0000;
            rate_q <= 6'h00;
        end else begin
            rx_ws_p_q <= rx_ws;
            if (!in_cfg_q[aoic_pkg::IN_RDIS_BIT]) begin
                if (rx_ws && !rx_ws_p_q) begin
                    rate_q <= rate_code(per_q);
                    per_q <= 16'h0001;
                end else if (32'(per_q) >= aoic_pkg::RATE_NONE_CYCLES) begin
                    rate_q <= 6'h00;
                end else begin
                    per_q <= per_q + 16'h0001;
                end
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence out_frozen;
        out_hold [*2];
    endsequence
    sequence stage_walk;
        s1_v_q ##1 s2_v_q ##1 proc_v_q;
    endsequence

    dmx_mono_a: assert property (
        demod_valid && dmx_sel == aoic_pkg::AOIC_DMX_MONO
        |=> s1_l_q == s1_r_q) else $error("mono output differs");
    dmx_straight_a: assert property (
        demod_valid && dmx_sel == aoic_pkg::AOIC_DMX_LR
        |=> s1_l_q == $past(demod_ch1) && s1_r_q == $past(demod_ch2))
        else $error("straight mode altered samples");
    startup_mute_a: assert property (startup_q && $past(startup_q)
        |-> dac_left == 16'sh0000 && $stable(serial_out_data))
        else $error("output active during startup");
    bal_unity_a: assert property (s1_v_q && bal_q[6]
        |=> s2_l_q == $past(s1_l_q)) else $error("left changed by balance");
    bal_order_a: assert property (s1_v_q |-> stage_walk)
        else $error("balance not ahead of volume");
    zero_atten_a: assert property (
        s2_v_q && vol_q[5:0] == 6'h00 && !src_mute
        |=> proc_l_q == $past(s2_l_q)) else $error("zero volume not unity");
    out_freeze_a: assert property (out_frozen
        |-> ($stable(serial_out_bit_clock) || $past(route_q[0]))
        && $stable(serial_out_word_clock)
        && $stable(serial_out_data)) else $error("muted output pins moved");
    master_pins_a: assert property (in_master && !route_q[1]
        |=> !serial_in_bit_clock_pin_oe_n && !serial_in_word_clock_pin_oe_n)
        else $error("master input not driving clocks");
    osc_in_pins_a: assert property (route_q[1] |=> !serial_in_data_pin_oe_n
        && serial_in_bit_clock_pin_o == $past(cnt_q[0]))
        else $error("oversample clock missing on input pin");
    loop_data_a: assert property (route_q[3] && !out_hold
        |=> serial_out_data == $past(pin_s2_q[0]))
        else $error("loop-through data mismatch");
    rate_hold_a: assert property (in_cfg_q[2] && $past(in_cfg_q[2])
        |-> $stable(rate_q)) else $error("rate changed while disabled");

endmodule

/* File: tb/aoic_i2s_src.sv */
`timescale 1ns/1ps
// External transmitter on the input port; its bit clock runs without a pause between frames while run is high.
module aoic_i2s_src (
    input wire logic run,
    input wire logic [31:0] left,
    input wire logic [31:0] right,
    output logic bclk,
    output logic wclk,
    output logic data
);
    int k;
    initial {bclk, wclk, data} = 3'b000;
    // Sends 32-bit slots, MSB one bit after the word edge, changing on falls.
    always begin
        if (!run) begin
            wait (run);
            #3;
        end
        for (int i = 0; i < 64; i++) begin
            k = (i + 63) % 64;
            #80 bclk = 1'b0;
            wclk = (i >= 32);
            data = (k < 32) ? left[31 - k] : right[63 - k];
            #80 bclk = 1'b1;
        end
        if (!run) data = ~data;
    end
endmodule

/* File: tb/audio_output_and_i2s_control_tb.sv */
`timescale 1ns/1ps
// Register traffic over the bus and a live serial stream into the input port.
module audio_output_and_i2s_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [23:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, L = '0, R = '0, rnd = 32'h3a26_df8a;
    logic pready, pslverr, rx_valid, run = 0, rx_on = 0;
    logic signed [15:0] rx_left, rx_right, dac_left, dac_right;
    logic dv = 0, dac_valid;
    logic [31:0] dq[$];
    logic bck, wck, dat, bck_oe_n;
    logic [32:0] q[$];
    logic [23:0] ad [7] = '{aoic_pkg::ADDR_IN_CFG, aoic_pkg::ADDR_IN_RATE,
        aoic_pkg::ADDR_OUT_CFG, aoic_pkg::ADDR_PATH, aoic_pkg::ADDR_VOL,
        aoic_pkg::ADDR_BAL, aoic_pkg::ADDR_ROUTE};
    int fail_count = 0, comparisons = 0;
    // Free-running system clock.
    always #10 pclk = ~pclk;
    aoic_top #(.STARTUP_CYCLES(16)) dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_left,
        .rx_right, .rx_valid, .demod_ch1(rnd[15:0]), .demod_ch2(rnd[31:16]),
        .demod_valid(dv), .demod_auto_mode(2'b00), .demod_lock_lost(1'b0),
        .serial_in_bit_clock_pin_i(bck), .serial_in_bit_clock_pin_o(),
        .serial_in_bit_clock_pin_oe_n(bck_oe_n),
        .serial_in_word_clock_pin_i(wck), .serial_in_word_clock_pin_o(),
        .serial_in_word_clock_pin_oe_n(), .serial_in_data_pin_i(dat),
        .serial_in_data_pin_o(), .serial_in_data_pin_oe_n(),
        .serial_out_bit_clock(), .serial_out_word_clock(),
        .serial_out_data(), .dac_left, .dac_right, .dac_valid);
    aoic_i2s_src src (.run(run), .left(L), .right(R), .bclk(bck),
        .wclk(wck), .data(dat));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // One bus transfer; the expected read data and error flag are queued.
    task automatic xfer(input logic w, input logic [23:0] a,
        input logic [31:0] d, input logic [32:0] e);
        q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Compares each completed transfer with the oldest queued note.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk({pwrite ? 32'h0 : prdata, pslverr}, q.pop_front());
        end
    end
    // Received samples keep the upper sixteen bits of each word.
    always @(posedge pclk) begin
        if (rx_on && rx_valid === 1'b1) begin
            chk({17'h0, rx_left}, {17'h0, L[31:16]});
            chk({17'h0, rx_right}, {17'h0, R[31:16]});
        end
    end
    // Converter samples at the next frame follow the queued decoded pair.
    always @(posedge pclk) begin
        if (dac_valid === 1'b1 && dq.size() > 0) begin
            chk({1'b0, dac_left, dac_right}, {1'b0, dq.pop_front()});
        end
    end
    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        conclude();
    end
    // Main sequence.
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ad[i]) xfer(1'b0, ad[i], 32'h0, 33'h0);
        rnd <= lfsr(rnd);
        @(posedge pclk);
        xfer(1'b1, aoic_pkg::ADDR_VOL, rnd, 33'h0);
        xfer(1'b0, aoic_pkg::ADDR_VOL, 0, {16'h0, rnd[15:0], 1'b0});
        xfer(1'b1, aoic_pkg::ADDR_BAL, 32'hffff_ffff, 33'h0);
        xfer(1'b0, aoic_pkg::ADDR_BAL, 0, {32'h0000_007f, 1'b0});
        xfer(1'b1, aoic_pkg::ADDR_IN_RATE, rnd, 33'h1);
        xfer(1'b0, 24'h32_0000, 0, 33'h1);
        xfer(1'b1, aoic_pkg::ADDR_ROUTE, 32'h0000_0006, 33'h0);
        xfer(1'b0, aoic_pkg::ADDR_ROUTE, 0, {32'h0000_0006, 1'b0});
        xfer(1'b1, aoic_pkg::ADDR_ROUTE, 0, 33'h0);
        xfer(1'b1, aoic_pkg::ADDR_VOL, 0, 33'h0);
        xfer(1'b1, aoic_pkg::ADDR_BAL, 32'h0000_0046, 33'h0);
        xfer(1'b1, aoic_pkg::ADDR_PATH, 32'h0000_9500, 33'h0);
        do @(posedge pclk); while (dac_valid !== 1'b1);
        dv <= 1'b1;
        @(posedge pclk);
        dv <= 1'b0;
        dq.push_back({rnd[15:0], $signed(rnd[31:16]) >>> 1});
        L = lfsr(rnd);
        R = lfsr(L);
        run <= 1'b1;
        repeat (1600) @(posedge pclk);
        rx_on <= 1'b1;
        chk({32'h0, bck_oe_n}, 33'h1);
        repeat (3000) @(posedge pclk);
        xfer(1'b0, aoic_pkg::ADDR_IN_RATE, 0, {32'h0000_0002, 1'b0});
        rx_on <= 1'b0;
        xfer(1'b1, aoic_pkg::ADDR_IN_CFG, 32'h0000_0005, 33'h0);
        repeat (2) @(posedge pclk);
        chk({32'h0, bck_oe_n}, 33'h0);
        repeat (1100) @(posedge pclk);
        xfer(1'b0, aoic_pkg::ADDR_IN_RATE, 0, {32'h0000_0002, 1'b0});
        conclude();
    end
endmodule
